// ==== dv/cdbu_checker.sv ====
/* Checker for cdbu_top: bus handshakes, debug entry and stop mask.
   Sees only top ports; bound after the module. */
`timescale 1ns/1ps
`default_nettype none
module cdbu_checker import cdbu_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register bus
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // Debug
  input wire logic i_host_req,
  input wire logic o_debug_enter,
  input wire logic o_debug_mode,
  input wire logic [7:0] o_core_stop
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_read_one_cycle: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  // Address and data both held with no response pending: answer next cycle
  a_write_answer: assert property (!o_awready && !o_wready && !o_bvalid |=> o_bvalid)
    else $error("write response late");
  a_enter_pulse: assert property (o_debug_enter |=> !o_debug_enter)
    else $error("entry pulse too long");
  a_enter_mode: assert property (o_debug_enter |-> o_debug_mode)
    else $error("entry without debug mode");
  a_host_enter: assert property (i_host_req && !o_debug_mode |-> ##[1:3] o_debug_mode)
    else $error("host request ignored");
  // Stop clears on the same edge that mode rises; the check still skips the first mode cycle
  a_stop_debug: assert property (o_debug_mode && $past(o_debug_mode) |-> o_core_stop == 8'h00)
    else $error("cores stopped in debug mode");
endmodule // cdbu_checker
bind cdbu_top cdbu_checker u_cdbu_checker (.i_clk, .i_rstn, .i_arvalid, .o_arready, .o_awready,
  .o_wready, .o_bresp, .o_bvalid, .i_bready, .o_rdata, .o_rvalid, .i_rready, .i_host_req,
  .o_debug_enter, .o_debug_mode, .o_core_stop);
`default_nettype wire

// ==== dv/cdbu_pipe_model.sv ====
/* Pipeline model: turns a bench command into one event pulse.
   Assumes the bench holds i_go for exactly one cycle. */
`timescale 1ns/1ps
`default_nettype none
module cdbu_pipe_model import cdbu_pkg::*; (
  // Command
  input wire logic i_go,
  input wire logic [2:0] i_kind,
  input wire logic [7:0] i_core,
  input wire logic [1:0] i_idx,
  input wire logic [31:0] i_val,
  input wire logic [7:0] i_stop,
  // Toward the block
  output cdbu_issue_t o_issue,
  output logic o_host_req,
  output logic o_call_req,
  output logic [7:0] o_call_core,
  output cdbu_wp_t o_wp
);
  logic [31:0] v;
  always_comb begin
    // Idle payload inverted so a stale value never looks valid
    v = i_go ? i_val : ~i_val;
    // Stopped cores never issue
    o_issue = {i_go && i_kind == CDBU_CAUSE_IBP && !i_stop[i_core[2:0]], i_core, v, ~v};
    o_host_req = i_go && i_kind == CDBU_CAUSE_HOST;
    o_call_req = i_go && i_kind == CDBU_CAUSE_CALL;
    o_call_core = i_go ? i_core : ~i_core;
    o_wp = {i_go && i_kind == CDBU_CAUSE_DWP, i_go && i_kind == CDBU_CAUSE_RWP, i_idx, i_core, v};
  end
endmodule // cdbu_pipe_model
`default_nettype wire

// ==== dv/cdbu_top_tb_top.sv ====
/* Bench for cdbu_top: reset, then register rows, refusal and entries.
   Assumes the pipeline model drives every event input. */
`timescale 1ns/1ps
`default_nettype none
module cdbu_top_tb_top import cdbu_pkg::*; ;
  typedef struct packed {logic [7:0] ix; logic [31:0] w; logic [31:0] e;} cdbu_row_t;
  logic i_clk = 0, i_rstn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
  logic i_rready = 0, go = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_debug_enter, o_debug_mode, o_irq, i_host_req, i_call_req;
  logic [11:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = '0, val = '0, o_rdata, d;
  logic [1:0] o_bresp, o_rresp, r, idx = '0;
  logic [7:0] o_core_stop, o_read_core, i_call_core, core = '0;
  logic [4:0] o_read_reg;
  logic [2:0] kind = '0;
  logic [3:0] i_wstrb = 4'hF;
  cdbu_issue_t i_issue;
  cdbu_wp_t i_wp;
  int n_mismatch = 0, checked = 0;
  cdbu_row_t rows [11] = '{'{CDBU_IDX_SPC, 32'hA5A5_0001, 32'hA5A5_0001},
    '{CDBU_IDX_SSP, 32'h5A5A_0002, 32'h5A5A_0002}, '{CDBU_IDX_TGT, 32'hFFFF_FFA7, 32'h0000_00A7},
    '{CDBU_IDX_RIDX, 32'hFFFF_FFF3, 32'h0000_0013}, '{CDBU_IDX_CAUSE, 32'hFFFF_FFFF, 32'h0003_FF07},
    '{CDBU_IDX_DATA, 32'h1234_5678, 32'h1234_5678}, '{CDBU_IDX_SCR, 32'hCAFE_0000, 32'hCAFE_0000},
    '{CDBU_IDX_SCR + 8'h07, 32'hCAFE_0007, 32'hCAFE_0007},
    '{CDBU_IDX_BPA + 8'h03, 32'h0000_0300, 32'h0000_0300},
    '{CDBU_IDX_BPC + 8'h03, 32'hFFFF_FFFC, 32'h00FF_0000},
    '{CDBU_IDX_STOP, 32'hFFFF_FF04, 32'h0000_0004}};
  cdbu_top u_cdbu_top (.i_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_issue, .i_host_req, .i_call_req, .i_call_core,
    .i_wp, .o_debug_enter, .o_debug_mode, .o_core_stop, .o_read_core, .o_read_reg, .o_irq);
  cdbu_pipe_model u_cdbu_pipe_model (.i_go(go), .i_kind(kind), .i_core(core), .i_idx(idx),
    .i_val(val), .i_stop(o_core_stop), .o_issue(i_issue), .o_host_req(i_host_req),
    .o_call_req(i_call_req), .o_call_core(i_call_core), .o_wp(i_wp));
  always #5 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] w);
    int t;
    @(posedge i_clk);
    i_awaddr <= {2'b00, ix, 2'b00};
    i_wdata <= w;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    for (t = 0; t < 50 && !(o_bvalid && i_bready); t++) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end
    i_bready <= 0;
    r = o_bresp;
    if (t == 50) n_mismatch++;
  endtask
  task automatic rd(input logic [7:0] ix);
    int t;
    @(posedge i_clk);
    i_araddr <= {2'b00, ix, 2'b00};
    i_arvalid <= 1;
    i_rready <= 1;
    for (t = 0; t < 50 && !(o_rvalid && i_rready); t++) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 0;
    end
    i_rready <= 0;
    d = o_rdata;
    r = o_rresp;
    if (t == 50) n_mismatch++;
  endtask
  task automatic trig(input logic [2:0] k, input logic [7:0] c, input logic [31:0] v);
    @(posedge i_clk);
    kind <= k;
    core <= c;
    val <= v;
    go <= 1;
    @(posedge i_clk);
    go <= 0;
  endtask
  task automatic no_entry(input logic [2:0] k, input logic [7:0] c, input logic [31:0] v);
    trig(k, c, v);
    repeat (6) @(posedge i_clk);
    cmp("no entry", 0, o_debug_mode);
  endtask
  task automatic entry(input logic [2:0] k, input logic [7:0] c, input logic [31:0] v,
    input logic [31:0] ec, input logic [7:0] pix, input logic [31:0] pv, input logic ei);
    int t;
    trig(k, c, v);
    for (t = 0; t < 10 && o_debug_enter !== 1'b1; t++) @(posedge i_clk);
    @(posedge i_clk);
    cmp("mode stop irq", {22'h0, 1'b1, 8'h00, ei}, {22'h0, o_debug_mode, o_core_stop, o_irq});
    rd(CDBU_IDX_CAUSE);
    cmp("cause", ec, d);
    rd(pix);
    cmp("captured", pv, d);
    wr(CDBU_IDX_DBG, 32'h0000_0000);
    wr(CDBU_IDX_IRQ_ST, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    cmp("after exit", {1'b0, 8'h04, 1'b0}, {o_debug_mode, o_core_stop, o_irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10000) @(posedge i_clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1;
    cmp("reset outputs", 32'h7, {o_debug_enter, o_debug_mode, o_irq, o_core_stop,
      o_awready, o_wready, o_arready});
    rd(CDBU_IDX_BPC);
    cmp("control reset", 0, d);
    rd(CDBU_IDX_CAUSE);
    cmp("cause reset", 0, d & 32'h7);
    foreach (rows[i]) begin
      wr(rows[i].ix, rows[i].w);
      rd(rows[i].ix);
      cmp("row", rows[i].e, d);
    end
    cmp("operands", 32'h0000_A713, {o_read_core, 3'b000, o_read_reg});
    rd(8'h17);
    cmp("unmapped read", CDBU_RESP_DECERR, r);
    wr(8'h17, 32'hFFFF_FFFF);
    cmp("unmapped write", CDBU_RESP_DECERR, r);
    wr(CDBU_IDX_IRQ_MSK, 32'h0000_0001);
    wr(CDBU_IDX_BPA + 8'h01, 32'h0000_0100);
    wr(CDBU_IDX_BPA + 8'h02, 32'h0000_0100);
    wr(CDBU_IDX_BPC + 8'h01, 32'h0008_0000);
    no_entry(CDBU_CAUSE_IBP, 8'h03, 32'h0000_0100);
    wr(CDBU_IDX_BPC + 8'h01, 32'h0008_0001);
    wr(CDBU_IDX_BPC + 8'h02, 32'h0008_0001);
    no_entry(CDBU_CAUSE_IBP, 8'h04, 32'h0000_0100);
    entry(CDBU_CAUSE_IBP, 8'h03, 32'h0000_0100, 32'h0001_0303, CDBU_IDX_SPC, 32'h100, 1);
    rd(CDBU_IDX_SSP);
    cmp("saved stack", 32'hFFFF_FEFF, d);
    wr(CDBU_IDX_BPC + 8'h01, 32'h0000_0000);
    wr(CDBU_IDX_BPC + 8'h02, 32'h0000_0000);
    wr(CDBU_IDX_BPC + 8'h03, 32'h0010_0003);
    no_entry(CDBU_CAUSE_IBP, 8'h04, 32'h0000_0300);
    entry(CDBU_CAUSE_IBP, 8'h04, 32'h0000_0200, 32'h0003_0403, CDBU_IDX_SPC, 32'h200, 1);
    wr(CDBU_IDX_BPC + 8'h03, 32'h0000_0000);
    entry(CDBU_CAUSE_HOST, 8'h09, 0, 32'h1, CDBU_IDX_CAUSE, 32'h1, 1);
    entry(CDBU_CAUSE_CALL, 8'h05, 0, 32'h502, CDBU_IDX_CAUSE, 32'h502, 1);
    idx <= 2'd2;
    entry(CDBU_CAUSE_DWP, 8'h06, 32'hDEAD_BEEF, 32'h2_0604, CDBU_IDX_DATA, 32'hDEAD_BEEF, 1);
    idx <= 2'd1;
    entry(CDBU_CAUSE_RWP, 8'h07, 32'h42, 32'h1_0705, CDBU_IDX_DATA, 32'h42, 1);
    wr(CDBU_IDX_IRQ_MSK, 32'h0000_0000);
    entry(CDBU_CAUSE_HOST, 8'h00, 0, 32'h1, CDBU_IDX_CAUSE, 32'h1, 0);
    end_of_test();
  end
endmodule // cdbu_top_tb_top
`default_nettype wire

// ==== hdl/cdbu_pkg.sv ====
/*
  Package for the core debug breakpoint unit: register indices, field
  layouts, cause codes and carrier structs.
  Assumes a single 100 MHz tile clock and AXI4-Lite register access.
*/
package cdbu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CDBU_IDX_SPC = 8'h11;
  localparam logic [7:0] CDBU_IDX_SSP = 8'h12;
  localparam logic [7:0] CDBU_IDX_TGT = 8'h13;
  localparam logic [7:0] CDBU_IDX_RIDX = 8'h14;
  localparam logic [7:0] CDBU_IDX_CAUSE = 8'h15;
  localparam logic [7:0] CDBU_IDX_DATA = 8'h16;
  localparam logic [7:0] CDBU_IDX_STOP = 8'h18;
  localparam logic [7:0] CDBU_IDX_SCR = 8'h20;
  localparam logic [7:0] CDBU_IDX_BPA = 8'h30;
  localparam logic [7:0] CDBU_IDX_BPC = 8'h40;
  localparam logic [7:0] CDBU_IDX_IRQ_ST = 8'hF0;
  localparam logic [7:0] CDBU_IDX_IRQ_MSK = 8'hF1;
  localparam logic [7:0] CDBU_IDX_DBG = 8'hF2;

  localparam int CDBU_NSCR = 8;
  localparam int CDBU_NBP = 4;
  localparam int CDBU_NCORE = 8;

  // Field masks (reserved bits zero)
  localparam logic [31:0] CDBU_TGT_MASK = 32'h0000_00FF;
  localparam logic [31:0] CDBU_RIDX_MASK = 32'h0000_001F;
  localparam logic [31:0] CDBU_CAUSE_MASK = 32'h0003_FF07;
  localparam logic [31:0] CDBU_STOP_MASK = 32'h0000_00FF;
  localparam logic [31:0] CDBU_BPC_MASK = 32'h00FF_0003;
  localparam logic [31:0] CDBU_IRQ_MASK = 32'h0000_0001;
  localparam logic [31:0] CDBU_DBG_MASK = 32'h0000_0001;
  localparam int CDBU_BPC_EN = 0;
  localparam int CDBU_BPC_INV = 1;
  localparam int CDBU_BPC_CORE_LO = 16;
  localparam int CDBU_CAUSE_IDX_LO = 16;
  localparam int CDBU_CAUSE_CORE_LO = 8;

  // Cause codes
  localparam logic [2:0] CDBU_CAUSE_NONE = 3'h0;
  localparam logic [2:0] CDBU_CAUSE_HOST = 3'h1;
  localparam logic [2:0] CDBU_CAUSE_CALL = 3'h2;
  localparam logic [2:0] CDBU_CAUSE_IBP = 3'h3;
  localparam logic [2:0] CDBU_CAUSE_DWP = 3'h4;
  localparam logic [2:0] CDBU_CAUSE_RWP = 3'h5;

  localparam logic [1:0] CDBU_RESP_OK = 2'h0;
  localparam logic [1:0] CDBU_RESP_DECERR = 2'h3;

  // Watchpoint hit from the pipeline
  typedef struct packed {
    logic data_hit;
    logic res_hit;
    logic [1:0] index;
    logic [7:0] core;
    logic [31:0] value;
  } cdbu_wp_t;

  // Context of the instruction being issued
  typedef struct packed {
    logic valid;
    logic [7:0] core;
    logic [31:0] pc;
    logic [31:0] sp;
  } cdbu_issue_t;

endpackage

// ==== hdl/cdbu_top.sv ====
/*
  Core debug breakpoint unit: debug register file over AXI4-Lite,
  instruction breakpoints, cause capture, stop mask and interrupt.
  Assumes the pipeline supplies issue context, host and call requests
  and watchpoint hits as single-cycle pulses on the tile clock.
*/
// What this block does
// - Cause field bits 2:0: host 1, call 2, breakpoint 3, data 4, resource 5.
// - Breakpoint or watchpoint index in bits 17:16, lowest index when several fire.
// - Causing core number in bits 15:8, zero when no core caused it.
// - Payload takes data watch address, or resource id on resource watch.
// - Saved program counter copied into a read-write register on debug entry.
// - Saved stack pointer copied into a read-write register on debug entry.
// - Register read operands: eight-bit target core and five-bit register index.
// - Stop mask bits block their cores whenever not in debug mode.
// - Eight 32-bit scratch words shared with the external debugger.
// - Four breakpoint address registers; qualifying match raises debug interrupt.
// - Each breakpoint acts only while its enable bit, reset zero, is set.
// - Per-core enable mask per breakpoint, reset zero, gates triggering.
// - Inversion bit makes a breakpoint fire on program counter mismatch.
`timescale 1ns/1ps
`default_nettype none
module cdbu_top import cdbu_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // AXI4-Lite slave
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Pipeline events
  input wire cdbu_issue_t i_issue,
  input wire logic i_host_req,
  input wire logic i_call_req,
  input wire logic [7:0] i_call_core,
  input wire cdbu_wp_t i_wp,
  // Debug control
  output logic o_debug_enter,
  output logic o_debug_mode,
  output logic [7:0] o_core_stop,
  output logic [7:0] o_read_core,
  output logic [4:0] o_read_reg,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] spc_q, spc_d, ssp_q, ssp_d, data_q, data_d;
  logic [31:0] tgt_q, tgt_d, ridx_q, ridx_d, cause_q, cause_d;
  logic [31:0] stop_q, stop_d, ist_q, ist_d, imsk_q, imsk_d;
  logic [31:0] scr_q [CDBU_NSCR];
  logic [31:0] scr_d [CDBU_NSCR];
  logic [31:0] bpa_q [CDBU_NBP];
  logic [31:0] bpa_d [CDBU_NBP];
  logic [31:0] bpc_q [CDBU_NBP];
  logic [31:0] bpc_d [CDBU_NBP];
  logic dbg_q, dbg_d, enter_q, enter_d;

  // AXI state
  logic [11:0] awa_q, awa_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  ////////////////////////////////////////////////////////////////////////
  // Breakpoint match, one per breakpoint
  logic [CDBU_NBP-1:0] bp_hit;
  genvar g;
  generate
    for (g = 0; g < CDBU_NBP; g++) begin : g_bp
      logic eq;
      assign eq = (i_issue.pc == bpa_q[g]);
      assign bp_hit[g] = i_issue.valid && !dbg_q
        && bpc_q[g][CDBU_BPC_EN]
        && bpc_q[g][CDBU_BPC_CORE_LO + i_issue.core[2:0]]
        && (i_issue.core < 8'(CDBU_NCORE))
        && (eq ^ bpc_q[g][CDBU_BPC_INV]);
    end
  endgenerate

  // Lowest firing index
  logic [1:0] bp_idx;
  always_comb begin
    bp_idx = 2'h0;
    for (int i = CDBU_NBP - 1; i >= 0; i--) begin
      if (bp_hit[i]) begin
        bp_idx = 2'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debug entry; host wins, then call, breakpoint, watchpoints
  logic trig;
  logic [2:0] trig_cause;
  logic [1:0] trig_idx;
  logic [7:0] trig_core;
  logic trig_pay;
  always_comb begin
    trig = 1'b0;
    trig_cause = CDBU_CAUSE_NONE;
    trig_idx = 2'h0;
    trig_core = 8'h00;
    trig_pay = 1'b0;
    if (!dbg_q) begin
      if (i_host_req) begin
        trig = 1'b1;
        trig_cause = CDBU_CAUSE_HOST;
      end else if (i_call_req) begin
        trig = 1'b1;
        trig_cause = CDBU_CAUSE_CALL;
        trig_core = i_call_core;
      end else if (|bp_hit) begin
        trig = 1'b1;
        trig_cause = CDBU_CAUSE_IBP;
        trig_idx = bp_idx;
        trig_core = i_issue.core;
      end else if (i_wp.data_hit || i_wp.res_hit) begin
        trig = 1'b1;
        trig_cause = i_wp.data_hit ? CDBU_CAUSE_DWP : CDBU_CAUSE_RWP;
        trig_idx = i_wp.index;
        trig_core = i_wp.core;
        trig_pay = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI handshake decode
  logic wr_go, rd_go;
  logic [11:0] wa;
  logic [31:0] wdat, wmask, wv;
  logic [7:0] widx, ridx;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign rd_go = i_arvalid && !rvalid_q;
  assign wa = awa_q;
  assign widx = wa[9:2];
  assign ridx = i_araddr[9:2];
  always_comb begin
    wmask = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{ws_q[b]}};
    end
  end
  assign wdat = wd_q;

  // Merge write data into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] bm, input logic [31:0] fm);
    merge = ((old & ~bm) | (nw & bm)) & fm;
  endfunction

  function automatic logic in_rng(input logic [7:0] idx, input logic [7:0] base,
                                  input int n);
    in_rng = (idx >= base) && (idx < base + 8'(n));
  endfunction

  logic wr_hit;
  always_comb begin
    wr_hit = (widx == CDBU_IDX_SPC) || (widx == CDBU_IDX_SSP) || (widx == CDBU_IDX_TGT)
      || (widx == CDBU_IDX_RIDX) || (widx == CDBU_IDX_CAUSE) || (widx == CDBU_IDX_DATA)
      || (widx == CDBU_IDX_STOP) || (widx == CDBU_IDX_IRQ_ST)
      || (widx == CDBU_IDX_IRQ_MSK) || (widx == CDBU_IDX_DBG)
      || in_rng(widx, CDBU_IDX_SCR, CDBU_NSCR) || in_rng(widx, CDBU_IDX_BPA, CDBU_NBP)
      || in_rng(widx, CDBU_IDX_BPC, CDBU_NBP);
    wr_hit = wr_hit && (wa[11:10] == 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////
  // Register next state
  always_comb begin
    logic wen;
    wen = wr_go && wr_hit;
    spc_d = spc_q;
    ssp_d = ssp_q;
    data_d = data_q;
    tgt_d = tgt_q;
    ridx_d = ridx_q;
    cause_d = cause_q;
    stop_d = stop_q;
    imsk_d = imsk_q;
    ist_d = ist_q;
    dbg_d = dbg_q;
    enter_d = 1'b0;
    for (int i = 0; i < CDBU_NSCR; i++) begin
      scr_d[i] = scr_q[i];
    end
    for (int i = 0; i < CDBU_NBP; i++) begin
      bpa_d[i] = bpa_q[i];
      bpc_d[i] = bpc_q[i];
    end
    if (wen) begin
      unique case (1'b1)
        widx == CDBU_IDX_SPC: spc_d = merge(spc_q, wdat, wmask, '1);
        widx == CDBU_IDX_SSP: ssp_d = merge(ssp_q, wdat, wmask, '1);
        widx == CDBU_IDX_TGT: tgt_d = merge(tgt_q, wdat, wmask, CDBU_TGT_MASK);
        widx == CDBU_IDX_RIDX: ridx_d = merge(ridx_q, wdat, wmask, CDBU_RIDX_MASK);
        widx == CDBU_IDX_CAUSE: cause_d = merge(cause_q, wdat, wmask, CDBU_CAUSE_MASK);
        widx == CDBU_IDX_DATA: data_d = merge(data_q, wdat, wmask, '1);
        widx == CDBU_IDX_STOP: stop_d = merge(stop_q, wdat, wmask, CDBU_STOP_MASK);
        widx == CDBU_IDX_IRQ_MSK: imsk_d = merge(imsk_q, wdat, wmask, CDBU_IRQ_MASK);
        widx == CDBU_IDX_DBG: dbg_d = wmask[0] ? (wdat[0] & dbg_q) : dbg_q;
        default: ;
      endcase
      if (widx == CDBU_IDX_IRQ_ST) begin
        ist_d = ist_q & ~(wdat & wmask & CDBU_IRQ_MASK);
      end
      for (int i = 0; i < CDBU_NSCR; i++) begin
        if (widx == CDBU_IDX_SCR + 8'(i)) begin
          scr_d[i] = merge(scr_q[i], wdat, wmask, '1);
        end
      end
      for (int i = 0; i < CDBU_NBP; i++) begin
        if (widx == CDBU_IDX_BPA + 8'(i)) begin
          bpa_d[i] = merge(bpa_q[i], wdat, wmask, '1);
        end
        if (widx == CDBU_IDX_BPC + 8'(i)) begin
          bpc_d[i] = merge(bpc_q[i], wdat, wmask, CDBU_BPC_MASK);
        end
      end
    end
    // Entry overrides software writes of the same cycle; set beats clear
    if (trig) begin
      dbg_d = 1'b1;
      enter_d = 1'b1;
      ist_d = ist_q | CDBU_IRQ_MASK;
      spc_d = i_issue.pc;
      ssp_d = i_issue.sp;
      cause_d = 32'h0000_0000;
      cause_d[2:0] = trig_cause;
      cause_d[CDBU_CAUSE_IDX_LO +: 2] = trig_idx;
      cause_d[CDBU_CAUSE_CORE_LO +: 8] = trig_core;
      if (trig_pay) begin
        data_d = i_wp.value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI next state
  always_comb begin
    awa_d = awa_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (i_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      awa_d = i_awaddr;
    end
    if (i_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wd_d = i_wdata;
      ws_d = i_wstrb;
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? CDBU_RESP_OK : CDBU_RESP_DECERR;
    end else if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = CDBU_RESP_OK;
      rdata_d = 32'h0000_0000;
      if (i_araddr[11:10] != 2'h0) begin
        rresp_d = CDBU_RESP_DECERR;
      end else begin
        unique case (1'b1)
          ridx == CDBU_IDX_SPC: rdata_d = spc_q;
          ridx == CDBU_IDX_SSP: rdata_d = ssp_q;
          ridx == CDBU_IDX_TGT: rdata_d = tgt_q;
          ridx == CDBU_IDX_RIDX: rdata_d = ridx_q;
          ridx == CDBU_IDX_CAUSE: rdata_d = cause_q;
          ridx == CDBU_IDX_DATA: rdata_d = data_q;
          ridx == CDBU_IDX_STOP: rdata_d = stop_q;
          ridx == CDBU_IDX_IRQ_ST: rdata_d = ist_q;
          ridx == CDBU_IDX_IRQ_MSK: rdata_d = imsk_q;
          ridx == CDBU_IDX_DBG: rdata_d = {31'h0, dbg_q};
          default: rresp_d = CDBU_RESP_DECERR;
        endcase
        for (int i = 0; i < CDBU_NSCR; i++) begin
          if (ridx == CDBU_IDX_SCR + 8'(i)) begin
            rdata_d = scr_q[i];
            rresp_d = CDBU_RESP_OK;
          end
        end
        for (int i = 0; i < CDBU_NBP; i++) begin
          if (ridx == CDBU_IDX_BPA + 8'(i)) begin
            rdata_d = bpa_q[i];
            rresp_d = CDBU_RESP_OK;
          end
          if (ridx == CDBU_IDX_BPC + 8'(i)) begin
            rdata_d = bpc_q[i];
            rresp_d = CDBU_RESP_OK;
          end
        end
      end
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flops; breakpoint control and mask clear on reset, data words do not
  always_ff @(posedge i_clk) begin
    spc_q <= spc_d;
    ssp_q <= ssp_d;
    data_q <= data_d;
    wd_q <= wd_d;
    ws_q <= ws_d;
    awa_q <= awa_d;
    rdata_q <= rdata_d;
    for (int i = 0; i < CDBU_NSCR; i++) begin
      scr_q[i] <= scr_d[i];
    end
    for (int i = 0; i < CDBU_NBP; i++) begin
      bpa_q[i] <= bpa_d[i];
    end
    if (!i_rstn) begin
      tgt_q <= 32'h0000_0000;
      ridx_q <= 32'h0000_0000;
      cause_q <= 32'h0000_0000;
      stop_q <= 32'h0000_0000;
      ist_q <= 32'h0000_0000;
      imsk_q <= 32'h0000_0000;
      dbg_q <= 1'b0;
      enter_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= CDBU_RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q <= CDBU_RESP_OK;
      for (int i = 0; i < CDBU_NBP; i++) begin
        bpc_q[i] <= 32'h0000_0000;
      end
    end else begin
      tgt_q <= tgt_d;
      ridx_q <= ridx_d;
      cause_q <= cause_d;
      stop_q <= stop_d;
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      dbg_q <= dbg_d;
      enter_q <= enter_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      for (int i = 0; i < CDBU_NBP; i++) begin
        bpc_q[i] <= bpc_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic [7:0] stop_o_q, rc_q;
  logic [4:0] rr_q;
  logic irq_q, mode_q, enter_o_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      stop_o_q <= 8'h00;
      rc_q <= 8'h00;
      rr_q <= 5'h00;
      irq_q <= 1'b0;
      mode_q <= 1'b0;
      enter_o_q <= 1'b0;
    end else begin
      stop_o_q <= dbg_d ? 8'h00 : stop_d[7:0];
      rc_q <= tgt_d[7:0];
      rr_q <= ridx_d[4:0];
      irq_q <= |(ist_d & imsk_d);
      mode_q <= dbg_d;
      enter_o_q <= enter_d;
    end
  end

  assign o_awready = !aw_have_q;
  assign o_wready = !w_have_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;
  assign o_core_stop = stop_o_q;
  assign o_read_core = rc_q;
  assign o_read_reg = rr_q;
  assign o_irq = irq_q;
  assign o_debug_mode = mode_q;
  assign o_debug_enter = enter_o_q;

endmodule // cdbu_top
`default_nettype wire
